// file: opdec.sv
/*
 * Decoder for the load, multiplicand, multiply, normalize, OR and
 * product-transfer slice of a 16-bit fixed-point core's instruction set.
 * Assumes instruction words arrive from program memory on the same clock,
 * one word per cycle when word_valid is high and word_ready was high.
 */
`timescale 1ns/1ps
`default_nettype none

`include "opdec_params.svh"

module opdec
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] word_in,
	input wire logic word_valid,
	output logic word_ready_reg,
	output logic issue_reg,
	output opdec_pkg::op_t op_reg,
	output logic [1:0] words_reg,
	output logic [2:0] cycles_reg,
	output logic mem_operand_reg,
	output logic indirect_reg,
	output logic [6:0] addr_field_reg,
	output logic [2:0] aux_reg_select_reg,
	output logic [15:0] imm_const_bits_reg,
	output logic [3:0] shift_count_field_reg,
	output logic illegal_reg
);
	import opdec_pkg::*;

	logic [7:0] hi;
	logic [7:0] lo;
	logic take;
	op_t dec_op;
	logic [1:0] dec_words;
	logic [2:0] dec_cycles;
	logic dec_mem;
	logic [15:0] dec_imm;
	fetch_t st_reg;
	fetch_t st_next;
	op_t pend_op_reg;
	logic [2:0] pend_cycles_reg;
	logic [7:0] pend_lo_reg;
	logic issue_next;
	logic [2:0] busy_reg;
	logic [2:0] busy_next;

	assign hi = word_in[15:8];
	assign lo = word_in[7:0];
	assign take = word_valid && word_ready_reg;

	// Pattern match on a first word. Shorter prefixes are tested ahead of the
	// byte table because their constant bits overlap several upper bytes.
	always_comb
	begin
		dec_op = op_illegal;
		dec_words = `WORDS_ONE;
		dec_cycles = `CYC_ONE;
		dec_mem = 1'b0;
		dec_imm = {8'h00, lo};
		if (word_in[15:13] == `PRE_MULT_IMM)
		begin
			dec_op = multiply_imm;
			dec_imm = {{3{word_in[12]}}, word_in[12:0]};
		end
		else if (word_in[15:9] == `PRE_PAGE_IMM)
		begin
			dec_op = page_ptr_load_imm;
			dec_cycles = `CYC_TWO;
			dec_imm = {7'h00, word_in[8:0]};
		end
		else if (word_in[15:11] == `PRE_AUX_SHORT)
		begin
			dec_op = aux_reg_load_short;
			dec_cycles = `CYC_TWO;
		end
		else if (word_in[15:11] == `PRE_AUX_MEM)
		begin
			dec_op = aux_reg_load_mem;
			dec_cycles = `CYC_TWO;
			dec_mem = 1'b1;
		end
		else
		begin
			unique case (hi)
				`PAT_ACC_LOW_SHORT: dec_op = load_acc_low_short_imm;
				`PAT_ACC_HIGH_ZERO: dec_op = load_acc_high_zero_low;
				`PAT_ACC_LOW_ZERO: dec_op = load_acc_low_zero_high;
				`PAT_ACC_TSHIFT: dec_op = load_acc_tshift;
				`PAT_PAGE_MEM:
				begin
					dec_op = page_ptr_load_mem;
					dec_cycles = `CYC_TWO;
				end
				`PAT_STATUS_ZERO, `PAT_STATUS_ONE:
				begin
					dec_op = (hi[0]) ? status_word_one_load
						: status_word_zero_load;
					dec_cycles = `CYC_TWO;
				end
				`PAT_HIGH_PRODUCT: dec_op = high_product_load;
				`PAT_FACTOR: dec_op = factor_reg_load;
				`PAT_FACTOR_ACCUM: dec_op = factor_load_accum;
				`PAT_FACTOR_MOVE: dec_op = factor_load_accum_move;
				`PAT_FACTOR_PRODUCT: dec_op = factor_load_product_move;
				`PAT_FACTOR_SUB: dec_op = factor_load_subtract;
				`PAT_MULT_SUM, `PAT_MULT_SUM_MOVE:
				begin
					dec_op = (hi[0]) ? mult_sum_data_move
						: mult_sum_prog_operand;
					dec_words = `WORDS_TWO;
					dec_cycles = `CYC_THREE;
				end
				`PAT_AUX_PTR:
				begin
					if (lo == `LO_NO_OP)
						dec_op = no_op;
					else if (lo[7:3] == `LO_AUX_SELECT)
						dec_op = aux_ptr_select;
					else
						dec_op = aux_ptr_modify;
				end
				`PAT_MULTIPLY, `PAT_MULTIPLY_U:
					dec_op = (hi[0]) ? multiply_no_sign
						: multiply_reg_by_data;
				`PAT_MULTIPLY_ADD: dec_op = multiply_add_prior;
				`PAT_MULTIPLY_SUB: dec_op = multiply_sub_prior;
				`PAT_ALIGN: dec_op = acc_leading_bit_align;
				`PAT_OR_MEM: dec_op = or_mem;
				`PAT_EXT_BF:
				begin
					if (lo[7:3] == `LO_AUX_LONG)
					begin
						dec_op = aux_reg_load_long;
						dec_words = `WORDS_TWO;
						dec_cycles = `CYC_TWO;
					end
					else if (lo[7:4] == `LO_OR_SHIFT)
					begin
						dec_op = or_imm_shift;
						dec_words = `WORDS_TWO;
						dec_cycles = `CYC_TWO;
					end
				end
				`PAT_EXT_BE:
				begin
					if (lo == `LO_OR_SHIFT16)
					begin
						dec_op = or_imm_shift16;
						dec_words = `WORDS_TWO;
						dec_cycles = `CYC_TWO;
					end
					else if (lo == `LO_PRODUCT_ACC)
						dec_op = product_to_acc;
					else if (lo == `LO_NEGATE)
						dec_op = acc_twos_complement;
					else if (lo == `LO_NMI)
					begin
						dec_op = nmi_raise;
						dec_cycles = `CYC_FOUR;
					end
				end
				default: dec_op = op_illegal;
			endcase
			// Constant, pointer-select and extended forms read no data word.
			dec_mem = (dec_op != op_illegal) && (dec_op != no_op)
				&& (dec_op != aux_ptr_select)
				&& (hi != `PAT_ACC_LOW_SHORT) && (hi != `PAT_EXT_BF)
				&& (hi != `PAT_EXT_BE);
		end
	end

	// Sequencer: a two-word instruction is held until its second word is in.
	always_comb
	begin
		st_next = st_reg;
		issue_next = 1'b0;
		if (take)
		begin
			unique case (st_reg)
				fetch_first:
				begin
					if (dec_words == `WORDS_TWO)
						st_next = fetch_second;
					else
						issue_next = 1'b1;
				end
				fetch_second:
				begin
					st_next = fetch_first;
					issue_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			st_reg <= fetch_first;
		else
			st_reg <= st_next;
	end

	// First-word state kept while the second word is awaited.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pend_op_reg <= op_none;
			pend_cycles_reg <= `CYC_ONE;
			pend_lo_reg <= 8'h00;
		end
		else if (take && st_reg == fetch_first)
		begin
			pend_op_reg <= dec_op;
			pend_cycles_reg <= dec_cycles;
			pend_lo_reg <= lo;
		end
	end

	// Remaining execution cycles after issue. The fetch cycles already spent
	// count toward the total, so the stall is cycles minus words.
	always_comb
	begin
		busy_next = busy_reg;
		if (issue_next)
		begin
			if (st_reg == fetch_second)
				busy_next = pend_cycles_reg - {1'b0, `WORDS_TWO};
			else
				busy_next = dec_cycles - {1'b0, `WORDS_ONE};
		end
		else if (busy_reg != 3'h0)
			busy_next = busy_reg - 3'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			busy_reg <= 3'h0;
			word_ready_reg <= 1'b0;
		end
		else
		begin
			busy_reg <= busy_next;
			word_ready_reg <= (busy_next == 3'h0);
		end
	end

	// Issued instruction, one pulse per completed instruction.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			issue_reg <= 1'b0;
			op_reg <= op_none;
			words_reg <= `WORDS_ONE;
			cycles_reg <= `CYC_ONE;
			imm_const_bits_reg <= 16'h0000;
			illegal_reg <= 1'b0;
		end
		else
		begin
			issue_reg <= issue_next;
			if (issue_next && st_reg == fetch_second)
			begin
				op_reg <= pend_op_reg;
				words_reg <= `WORDS_TWO;
				cycles_reg <= pend_cycles_reg;
				imm_const_bits_reg <= word_in;
				illegal_reg <= 1'b0;
			end
			else if (issue_next)
			begin
				op_reg <= dec_op;
				words_reg <= dec_words;
				cycles_reg <= dec_cycles;
				imm_const_bits_reg <= dec_imm;
				illegal_reg <= (dec_op == op_illegal);
			end
		end
	end

	// Operand fields of the issued instruction, from its first word.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mem_operand_reg <= 1'b0;
			indirect_reg <= 1'b0;
			addr_field_reg <= 7'h00;
			aux_reg_select_reg <= 3'h0;
			shift_count_field_reg <= 4'h0;
		end
		else if (issue_next && st_reg == fetch_second)
		begin
			mem_operand_reg <= (pend_op_reg == mult_sum_prog_operand)
				|| (pend_op_reg == mult_sum_data_move);
			indirect_reg <= pend_lo_reg[`FLD_INDIRECT];
			addr_field_reg <= pend_lo_reg[6:0];
			aux_reg_select_reg <= pend_lo_reg[2:0];
			shift_count_field_reg <= pend_lo_reg[3:0];
		end
		else if (issue_next)
		begin
			mem_operand_reg <= dec_mem;
			indirect_reg <= lo[`FLD_INDIRECT];
			addr_field_reg <= lo[6:0];
			if (dec_op == aux_ptr_select)
				aux_reg_select_reg <= lo[2:0];
			else
				aux_reg_select_reg <= hi[2:0];
			shift_count_field_reg <= lo[3:0];
		end
	end

endmodule

`default_nettype wire

// file: opdec_params.svh
/*
 * Opcode patterns, field positions and cycle counts for the load and
 * multiply instruction decoder.
 * Assumes it is included by its bare name from the decoder source.
 */
`ifndef OPDEC_PARAMS_SVH
`define OPDEC_PARAMS_SVH

// Upper-byte opcode patterns.
`define PAT_ACC_LOW_SHORT 8'hB9
`define PAT_ACC_HIGH_ZERO 8'h6A
`define PAT_ACC_LOW_ZERO 8'h69
`define PAT_ACC_TSHIFT 8'h6B
`define PAT_PAGE_MEM 8'h0D
`define PAT_STATUS_ZERO 8'h0E
`define PAT_STATUS_ONE 8'h0F
`define PAT_HIGH_PRODUCT 8'h75
`define PAT_FACTOR 8'h73
`define PAT_FACTOR_ACCUM 8'h70
`define PAT_FACTOR_MOVE 8'h72
`define PAT_FACTOR_PRODUCT 8'h71
`define PAT_FACTOR_SUB 8'h74
`define PAT_MULT_SUM 8'hA2
`define PAT_MULT_SUM_MOVE 8'hA3
`define PAT_AUX_PTR 8'h8B
`define PAT_MULTIPLY 8'h54
`define PAT_MULTIPLY_U 8'h55
`define PAT_MULTIPLY_ADD 8'h50
`define PAT_MULTIPLY_SUB 8'h51
`define PAT_ALIGN 8'hA0
`define PAT_OR_MEM 8'h6D
`define PAT_EXT_BF 8'hBF
`define PAT_EXT_BE 8'hBE

// Lower-byte patterns under the pointer and extended prefixes.
`define LO_NO_OP 8'h00
`define LO_AUX_SELECT 5'h11
`define LO_AUX_LONG 5'h01
`define LO_OR_SHIFT 4'hC
`define LO_OR_SHIFT16 8'h82
`define LO_PRODUCT_ACC 8'h03
`define LO_NEGATE 8'h02
`define LO_NMI 8'h52

// Short prefixes that span less than the upper byte.
`define PRE_MULT_IMM 3'h6
`define PRE_PAGE_IMM 7'h5E
`define PRE_AUX_SHORT 5'h16
`define PRE_AUX_MEM 5'h00

// Memory-operand field: bit 7 picks indirect addressing.
`define FLD_INDIRECT 7

// Instruction lengths in words and execution counts in cycles.
`define WORDS_ONE 2'h1
`define WORDS_TWO 2'h2
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4

`endif

// file: opdec_pkg.sv
/*
 * Types shared by the load and multiply instruction decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package opdec_pkg;

	// Decoded operation handed to the execution units.
	typedef enum logic [5:0] {
		op_none,
		load_acc_low_short_imm,
		load_acc_high_zero_low,
		load_acc_low_zero_high,
		load_acc_tshift,
		aux_reg_load_mem,
		aux_reg_load_short,
		aux_reg_load_long,
		page_ptr_load_mem,
		page_ptr_load_imm,
		high_product_load,
		status_word_zero_load,
		status_word_one_load,
		factor_reg_load,
		factor_load_accum,
		factor_load_accum_move,
		factor_load_product_move,
		factor_load_subtract,
		mult_sum_prog_operand,
		mult_sum_data_move,
		aux_ptr_select,
		aux_ptr_modify,
		no_op,
		multiply_reg_by_data,
		multiply_no_sign,
		multiply_imm,
		multiply_add_prior,
		multiply_sub_prior,
		acc_leading_bit_align,
		or_mem,
		or_imm_shift,
		or_imm_shift16,
		product_to_acc,
		acc_twos_complement,
		nmi_raise,
		op_illegal
	} op_t;

	// Fetch sequencer states.
	typedef enum logic [0:0] {
		fetch_first,
		fetch_second
	} fetch_t;

endpackage

`default_nettype wire

// file: opdec_sva.sv
/*
 * Port checker for the load and multiply instruction decoder.
 * Assumes one clock, mclk, and a synchronous active-high reset, rst.
 */
`timescale 1ns/1ps
`default_nettype none

module opdec_chk
import opdec_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] word_in,
	input wire logic word_valid,
	input wire logic word_ready_reg,
	input wire logic issue_reg,
	input wire opdec_pkg::op_t op_reg,
	input wire logic [1:0] words_reg,
	input wire logic [2:0] cycles_reg,
	input wire logic mem_operand_reg,
	input wire logic indirect_reg,
	input wire logic [6:0] addr_field_reg,
	input wire logic [2:0] aux_reg_select_reg,
	input wire logic [15:0] imm_const_bits_reg,
	input wire logic [3:0] shift_count_field_reg,
	input wire logic illegal_reg
);
	// All checks share one domain, so reset masks every one of them.
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_issue_after_take: assert property (
		issue_reg |-> $past(word_valid && word_ready_reg))
		else $error("issue without a taken word");
	a_illegal_flag_match: assert property (
		issue_reg |-> (illegal_reg == (op_reg == op_illegal)))
		else $error("illegal flag disagrees with op");
	a_nmi_stall_three: assert property (
		issue_reg && op_reg == nmi_raise |->
		!word_ready_reg [*3] ##1 word_ready_reg)
		else $error("interrupt stall is not three cycles");
	a_short_two_cycle: assert property (
		issue_reg && words_reg == 2'h1 && cycles_reg == 3'h2 |->
		!word_ready_reg ##1 word_ready_reg)
		else $error("one-word two-cycle stall wrong");
	a_mult_sum_length: assert property (
		issue_reg && (op_reg == mult_sum_prog_operand ||
		op_reg == mult_sum_data_move) |-> words_reg == 2'h2 &&
		cycles_reg == 3'h3 && !word_ready_reg ##1 word_ready_reg)
		else $error("multiply-sum length or stall wrong");
	a_operand_field_bits: assert property (
		issue_reg && words_reg == 2'h1 |->
		indirect_reg == $past(word_in[7]) &&
		addr_field_reg == $past(word_in[6:0]))
		else $error("operand field not from low byte");
	a_short_const_load: assert property (
		issue_reg && words_reg == 2'h1 &&
		$past(word_in[15:8]) == 8'hB9 |->
		op_reg == load_acc_low_short_imm &&
		imm_const_bits_reg == {8'h00, $past(word_in[7:0])})
		else $error("short constant load wrong");
	a_second_word_copy: assert property (
		issue_reg && words_reg == 2'h2 |->
		imm_const_bits_reg == $past(word_in))
		else $error("second word not copied");
	a_no_stall_ready: assert property (
		issue_reg && cycles_reg == {1'b0, words_reg} |-> word_ready_reg)
		else $error("needless stall");

	c_nmi: cover property (issue_reg && op_reg == nmi_raise);
	c_illegal: cover property (issue_reg && illegal_reg);
	c_two_word: cover property (issue_reg && words_reg == 2'h2);
endmodule

bind opdec opdec_chk opdec_chk_inst (.mclk(mclk), .rst(rst),
	.word_in(word_in), .word_valid(word_valid),
	.word_ready_reg(word_ready_reg), .issue_reg(issue_reg),
	.op_reg(op_reg), .words_reg(words_reg), .cycles_reg(cycles_reg),
	.mem_operand_reg(mem_operand_reg), .indirect_reg(indirect_reg),
	.addr_field_reg(addr_field_reg),
	.aux_reg_select_reg(aux_reg_select_reg),
	.imm_const_bits_reg(imm_const_bits_reg),
	.shift_count_field_reg(shift_count_field_reg),
	.illegal_reg(illegal_reg));

`default_nettype wire

// file: opdec_tb_top.sv
/*
 * Self-checking bench for the load and multiply instruction decoder.
 * Assumes the decoder takes words on valid and ready and issues a cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module opdec_tb_top;
	import opdec_pkg::*;

	typedef struct packed
	{
		logic [15:0] a;
		logic [15:0] b;
		op_t op;
		logic [1:0] n;
		logic [2:0] c;
	} row_t;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] word_in = 16'h0000;
	logic word_valid = 1'b0;
	logic word_ready_reg, issue_reg, mem_operand_reg, indirect_reg;
	logic illegal_reg;
	op_t op_reg;
	logic [1:0] words_reg;
	logic [2:0] cycles_reg, aux_reg_select_reg;
	logic [6:0] addr_field_reg;
	logic [15:0] imm_const_bits_reg;
	logic [3:0] shift_count_field_reg;
	int err_count = 0;
	int num_checks = 0;
	int k;
	row_t rows [0:33];

	// Half period of 5 ns gives the 100 MHz core clock.
	always #5 mclk = ~mclk;

	opdec opdec_inst (.mclk(mclk), .rst(rst), .word_in(word_in),
		.word_valid(word_valid), .word_ready_reg(word_ready_reg),
		.issue_reg(issue_reg), .op_reg(op_reg), .words_reg(words_reg),
		.cycles_reg(cycles_reg), .mem_operand_reg(mem_operand_reg),
		.indirect_reg(indirect_reg), .addr_field_reg(addr_field_reg),
		.aux_reg_select_reg(aux_reg_select_reg),
		.imm_const_bits_reg(imm_const_bits_reg),
		.shift_count_field_reg(shift_count_field_reg),
		.illegal_reg(illegal_reg));

	task automatic chk(string s, logic [15:0] e, logic [15:0] v);
		num_checks++;
		if (v !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", s, e, v);
		end
	endtask

	task automatic chk_op(op_t e);
		num_checks++;
		if (op_reg !== e || issue_reg !== 1'b1)
		begin
			err_count++;
			$display("BAD op expected %s seen %s", e.name(), op_reg.name());
		end
	endtask

	// Valid stays high between words so back-to-back takes are exercised.
	task automatic put(logic [15:0] w);
		int n;
		n = 0;
		word_in = w;
		word_valid = 1'b1;
		while (word_ready_reg !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("ready", 16'h0001, {15'h0, word_ready_reg});
		@(posedge mclk);
		#1;
	endtask

	// Counts the refused cycles that follow an issue.
	task automatic stall(int e);
		int n;
		n = 0;
		while (word_ready_reg !== 1'b1 && n < 9)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("stall", e[15:0], n[15:0]);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard, far beyond the hundred or so cycles the run needs.
	initial
	begin
		#100000;
		err_count++;
		test_done;
	end

	initial
	begin
		rows = '{
			'{16'hB912, 16'h0, load_acc_low_short_imm, 2'h1, 3'h1},
			'{16'h6A85, 16'h0, load_acc_high_zero_low, 2'h1, 3'h1},
			'{16'h6903, 16'h0, load_acc_low_zero_high, 2'h1, 3'h1},
			'{16'h6B11, 16'h0, load_acc_tshift, 2'h1, 3'h1},
			'{16'h0385, 16'h0, aux_reg_load_mem, 2'h1, 3'h2},
			'{16'hB57F, 16'h0, aux_reg_load_short, 2'h1, 3'h2},
			'{16'hBF0D, 16'h1234, aux_reg_load_long, 2'h2, 3'h2},
			'{16'h0D10, 16'h0, page_ptr_load_mem, 2'h1, 3'h2},
			'{16'hBD55, 16'h0, page_ptr_load_imm, 2'h1, 3'h2},
			'{16'h0E20, 16'h0, status_word_zero_load, 2'h1, 3'h2},
			'{16'h0F21, 16'h0, status_word_one_load, 2'h1, 3'h2},
			'{16'h7301, 16'h0, factor_reg_load, 2'h1, 3'h1},
			'{16'h7002, 16'h0, factor_load_accum, 2'h1, 3'h1},
			'{16'h7203, 16'h0, factor_load_accum_move, 2'h1, 3'h1},
			'{16'h7104, 16'h0, factor_load_product_move, 2'h1, 3'h1},
			'{16'h7405, 16'h0, factor_load_subtract, 2'h1, 3'h1},
			'{16'hA206, 16'hABCD, mult_sum_prog_operand, 2'h2, 3'h3},
			'{16'hA307, 16'h5A5A, mult_sum_data_move, 2'h2, 3'h3},
			'{16'h8B8E, 16'h0, aux_ptr_select, 2'h1, 3'h1},
			'{16'h8B90, 16'h0, aux_ptr_modify, 2'h1, 3'h1},
			'{16'h8B00, 16'h0, no_op, 2'h1, 3'h1},
			'{16'h5408, 16'h0, multiply_reg_by_data, 2'h1, 3'h1},
			'{16'h5509, 16'h0, multiply_no_sign, 2'h1, 3'h1},
			'{16'hD123, 16'h0, multiply_imm, 2'h1, 3'h1},
			'{16'h500A, 16'h0, multiply_add_prior, 2'h1, 3'h1},
			'{16'h510B, 16'h0, multiply_sub_prior, 2'h1, 3'h1},
			'{16'hA00C, 16'h0, acc_leading_bit_align, 2'h1, 3'h1},
			'{16'h6D0D, 16'h0, or_mem, 2'h1, 3'h1},
			'{16'hBFC5, 16'h00FF, or_imm_shift, 2'h2, 3'h2},
			'{16'hBE82, 16'h8001, or_imm_shift16, 2'h2, 3'h2},
			'{16'hBE03, 16'h0, product_to_acc, 2'h1, 3'h1},
			'{16'hBE02, 16'h0, acc_twos_complement, 2'h1, 3'h1},
			'{16'h7506, 16'h0, high_product_load, 2'h1, 3'h1},
			'{16'h0C00, 16'h0, op_illegal, 2'h1, 3'h1}
		};
		repeat (16) @(posedge mclk);
		#1;
		rst = 1'b0;
		// Every decoded pattern but the interrupt, back to back as the stalls allow.
		for (k = 0; k < 34; k++)
		begin
			put(rows[k].a);
			if (rows[k].n == 2'h2)
				put(rows[k].b);
			chk_op(rows[k].op);
			chk("words", {14'h0, rows[k].n}, {14'h0, words_reg});
			chk("cycles", {13'h0, rows[k].c}, {13'h0, cycles_reg});
		end
		chk("illegal", 16'h0001, {15'h0, illegal_reg});
		// Zero constant clears, with no gap after the previous issue.
		put(16'hB900);
		chk("imm", 16'h0000, imm_const_bits_reg);
		chk("illegal", 16'h0000, {15'h0, illegal_reg});
		chk("mem", 16'h0000, {15'h0, mem_operand_reg});
		put(16'hD123);
		chk("imm", 16'hF123, imm_const_bits_reg);
		put(16'h0385);
		chk("aux", 16'h0003, {13'h0, aux_reg_select_reg});
		chk("ind", 16'h0001, {15'h0, indirect_reg});
		chk("mem", 16'h0001, {15'h0, mem_operand_reg});
		stall(1);
		put(16'hBD55);
		chk("page", 16'h0155, imm_const_bits_reg);
		stall(1);
		put(16'h8B8E);
		chk("aux", 16'h0006, {13'h0, aux_reg_select_reg});
		put(16'hBE52);
		chk_op(nmi_raise);
		chk("cycles", 16'h0004, {13'h0, cycles_reg});
		stall(3);
		put(16'hA2F0);
		put(16'h0042);
		chk("imm", 16'h0042, imm_const_bits_reg);
		chk("addr", 16'h0070, {9'h0, addr_field_reg});
		chk("ind", 16'h0001, {15'h0, indirect_reg});
		chk("mem", 16'h0001, {15'h0, mem_operand_reg});
		stall(1);
		// Two-word forms take their fields from the held first word.
		put(16'hBFC7);
		put(16'h00F0);
		chk("shift", 16'h0007, {12'h0, shift_count_field_reg});
		chk("mem", 16'h0000, {15'h0, mem_operand_reg});
		chk("imm", 16'h00F0, imm_const_bits_reg);
		put(16'hBF0E);
		put(16'h1234);
		chk("aux", 16'h0006, {13'h0, aux_reg_select_reg});
		chk("imm", 16'h1234, imm_const_bits_reg);
		// Reset in the middle of a two-word fetch drops the half instruction.
		put(16'hBF0D);
		rst = 1'b1;
		@(posedge mclk);
		#1;
		chk("rdy", 16'h0000, {15'h0, word_ready_reg});
		chk("iss", 16'h0000, {15'h0, issue_reg});
		chk("op", {10'h000, op_none}, {10'h000, op_reg});
		chk("words", 16'h0001, {14'h0, words_reg});
		rst = 1'b0;
		put(16'h7301);
		chk_op(factor_reg_load);
		word_valid = 1'b0;
		repeat (4) @(posedge mclk);
		test_done;
	end
endmodule

`default_nettype wire
